// ===== core/dma_pkg.sv
/*
 * Shared constants and types of the four-channel transfer controller:
 * register offsets, field positions, reset values, source codes, states.
 * Assumes a 32-bit Wishbone register bus with byte addresses.
 */
package dma_pkg;
   localparam int NCH = 4;
   localparam int NSRC = 128;
   localparam int AW = 8;
   localparam int CNT_W = 14;

   // ************************************************
   // register map (word offsets)
   // ************************************************
   localparam logic [1:0] CH_SHIFT_LO = 2'd0;
   localparam logic [2:0] OFF_CTRL = 3'h0;
   localparam logic [2:0] OFF_REQ = 3'h1;
   localparam logic [2:0] OFF_STA = 3'h2;
   localparam logic [2:0] OFF_STB = 3'h3;
   localparam logic [2:0] OFF_PAD = 3'h4;
   localparam logic [2:0] OFF_CNT = 3'h5;
   localparam logic [4:0] OFF_STAT = 5'h00;
   localparam logic [4:0] OFF_MASK = 5'h01;

   // ************************************************
   // fields
   // ************************************************
   localparam int CTL_EN = 0;
   localparam int CTL_BYTE = 1;
   localparam int CTL_DIR = 2;
   localparam int CTL_AM_LO = 3;
   localparam int CTL_ONESHOT = 5;
   localparam int CTL_PP = 6;
   localparam int CTL_HALF = 7;
   localparam int REQ_FORCE = 15;
   localparam logic [15:0] CTRL_WMASK = 16'h00FF;
   localparam logic [15:0] REQ_WMASK = 16'h00FF;
   localparam logic [15:0] REG_RST = 16'h0000;

   localparam logic [1:0] AM_INC = 2'h0;
   localparam logic [1:0] AM_FIX = 2'h1;
   localparam logic [1:0] AM_PIND = 2'h2;

   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;

   // ************************************************
   // request source codes
   // ************************************************
   localparam logic [7:0] SRC_EXTERNAL_INTERRUPT_ZERO = 8'h00;
   localparam logic [7:0] SRC_TIMER_TWO_EVENT = 8'h07;
   localparam logic [7:0] SRC_ADC_DONE = 8'h0D;

   typedef enum logic [1:0] {ENG_IDLE = 2'b01, ENG_BUSY = 2'b10} eng_state_t;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] req;
      logic [15:0] sta;
      logic [15:0] stb;
      logic [15:0] pad;
      logic [CNT_W-1:0] cnt;
      logic [15:0] cur;
      logic [CNT_W-1:0] done_n;
      logic pp;
   } chan_t;
endpackage

// ===== core/arb_if.sv
/*
 * Request and grant lines between the transfer engine and its arbiter.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
interface arb_if;
   logic [3:0] req;
   logic [3:0] gnt;
   modport arb (input req, output gnt);
   modport eng (output req, input gnt);
endinterface

// ===== core/prio_arb.sv
/*
 * Fixed priority arbiter, channel 0 highest.
 * Assumes requests come from flops of the same clock.
 */
`timescale 1ns/1ps
module prio_arb
   import dma_pkg::*;
(
   arb_if.arb a
);
   // lowest set bit wins; losers keep their pending flag upstream
   assign a.gnt = a.req & (~a.req + 4'h1);
endmodule

// ===== core/src_sync.sv
/*
 * Request source synchroniser and per-channel source selection.
 * Assumes source lines are asynchronous levels; a rising edge is an event.
 */
`timescale 1ns/1ps
module src_sync
   import dma_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [NSRC-1:0] src_i,
   input wire logic [NCH*8-1:0] sel_i,
   output logic [NCH-1:0] ev_o
);
   typedef struct packed {
      logic [NSRC-1:0] s1;
      logic [NSRC-1:0] s2;
      logic [NSRC-1:0] s3;
   } sync_t;

   sync_t r;
   sync_t r_nxt;
   logic [NSRC-1:0] rise;

   always_comb begin
      r_nxt = r;
      r_nxt.s1 = src_i;
      r_nxt.s2 = r.s1;
      r_nxt.s3 = r.s2;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign rise = r.s2 & ~r.s3;

   // codes past the wired sources select nothing
   for (genvar c = 0; c < NCH; c++) begin : g_sel
      assign ev_o[c] = sel_i[c*8+7] ? 1'b0 : rise[sel_i[c*8 +: 7]];
   end
endmodule

// ===== core/dma_ctrl.sv
/*
 * Four-channel transfer controller: Wishbone register slave, pending
 * request tracking, single transfer engine, status and interrupt.
 * Assumes the transfer port partner completes a move and pulses
 * xfer_ack_i in the clock domain of clk_i.
 */
`timescale 1ns/1ps
module dma_ctrl
   import dma_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NSRC-1:0] src_i,
   input wire logic [15:0] pind_addr_i,
   output logic xfer_req_o,
   output logic [15:0] xfer_src_o,
   output logic [15:0] xfer_dst_o,
   output logic xfer_byte_o,
   input wire logic xfer_ack_i,
   output logic irq_o
);
   typedef struct packed {
      chan_t [NCH-1:0] ch;
      logic [NCH-1:0] pend;
      logic [2*NCH-1:0] stat;
      logic [2*NCH-1:0] mask;
      eng_state_t eng;
      logic [1:0] cur_ch;
      logic xreq;
      logic [15:0] xsrc;
      logic [15:0] xdst;
      logic xbyte;
      logic ack;
      logic [31:0] rdat;
   } dma_state_t;

   dma_state_t r;
   dma_state_t r_nxt;
   logic [NCH-1:0] ev;
   logic [NCH*8-1:0] sel;
   logic wr;
   logic rd;
   logic done_ev;
   logic [1:0] done_ch;
   logic fin;

   arb_if arb ();

   prio_arb u_arb (
      .a(arb.arb)
   );

   for (genvar c = 0; c < NCH; c++) begin : g_sel
      assign sel[c*8 +: 8] = r.ch[c].req[7:0];
      assign arb.req[c] = r.pend[c] & r.ch[c].ctrl[CTL_EN] & (r.eng == ENG_IDLE);
   end

   src_sync u_src (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .src_i(src_i),
      .sel_i(sel),
      .ev_o(ev)
   );

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be, input logic [15:0] wm);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}} & wm;
      merge16 = (old & ~m) | (d[15:0] & m);
   endfunction

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~r.ack;
   assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~r.ack;
   assign fin = (r.eng == ENG_BUSY) & xfer_ack_i;
   assign done_ch = r.cur_ch;
   assign done_ev = fin & (r.ch[r.cur_ch].done_n == r.ch[r.cur_ch].cnt);

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      logic [NCH-1:0] force_ev;
      logic [1:0] ci;
      logic [14:0] h15;
      logic [CNT_W-1:0] dn;
      chan_t cc;
      logic [15:0] maddr;
      logic [15:0] m16;
      force_ev = '0;
      ci = wb_adr_i[6:5];
      h15 = '0;
      dn = '0;
      cc = r.ch[r.cur_ch];
      maddr = '0;
      m16 = '0;
      r_nxt = r;
      r_nxt.ack = wb_cyc_i & wb_stb_i & ~r.ack;
      r_nxt.rdat = '0;

      // register reads; unmapped words answer zero
      if (rd) begin
         if (!wb_adr_i[7]) begin
            unique case (wb_adr_i[4:2])
               OFF_CTRL: r_nxt.rdat = {16'h0000, r.ch[ci].ctrl};
               OFF_REQ: r_nxt.rdat = {16'h0000, r.ch[ci].req};
               OFF_STA: r_nxt.rdat = {16'h0000, r.ch[ci].sta};
               OFF_STB: r_nxt.rdat = {16'h0000, r.ch[ci].stb};
               OFF_PAD: r_nxt.rdat = {16'h0000, r.ch[ci].pad};
               OFF_CNT: r_nxt.rdat = {18'h00000, r.ch[ci].cnt};
               default: r_nxt.rdat = '0;
            endcase
         end else if (wb_adr_i[6:2] == OFF_STAT) begin
            r_nxt.rdat = {24'h000000, r.stat};
         end else if (wb_adr_i[6:2] == OFF_MASK) begin
            r_nxt.rdat = {24'h000000, r.mask};
         end
      end

      // register writes
      if (wr) begin
         if (!wb_adr_i[7]) begin
            unique case (wb_adr_i[4:2])
               OFF_CTRL: begin
                  r_nxt.ch[ci].ctrl = merge16(r.ch[ci].ctrl, wb_dat_i, wb_sel_i, CTRL_WMASK);
                  // enabling loads the block from the first start address
                  if (!r.ch[ci].ctrl[CTL_EN] && r_nxt.ch[ci].ctrl[CTL_EN]) begin
                     r_nxt.ch[ci].cur = r.ch[ci].sta;
                     r_nxt.ch[ci].done_n = '0;
                     r_nxt.ch[ci].pp = 1'b0;
                  end
               end
               OFF_REQ: begin
                  r_nxt.ch[ci].req = merge16(r.ch[ci].req, wb_dat_i, wb_sel_i, REQ_WMASK);
                  force_ev[ci] = wb_dat_i[REQ_FORCE] & wb_sel_i[1];
               end
               OFF_STA: r_nxt.ch[ci].sta = merge16(r.ch[ci].sta, wb_dat_i, wb_sel_i, 16'hFFFF);
               OFF_STB: r_nxt.ch[ci].stb = merge16(r.ch[ci].stb, wb_dat_i, wb_sel_i, 16'hFFFF);
               OFF_PAD: r_nxt.ch[ci].pad = merge16(r.ch[ci].pad, wb_dat_i, wb_sel_i, 16'hFFFF);
               OFF_CNT: begin
                  // upper two bits are not stored
                  m16 = merge16({2'b00, r.ch[ci].cnt}, wb_dat_i, wb_sel_i, 16'h3FFF);
                  r_nxt.ch[ci].cnt = m16[CNT_W-1:0];
               end
               default: ;
            endcase
         end else if (wb_adr_i[6:2] == OFF_STAT && wb_sel_i[0]) begin
            r_nxt.stat = r.stat & ~wb_dat_i[2*NCH-1:0];
         end else if (wb_adr_i[6:2] == OFF_MASK && wb_sel_i[0]) begin
            r_nxt.mask = wb_dat_i[2*NCH-1:0];
         end
      end

      // ************************************************
      // transfer engine
      // ************************************************
      unique case (r.eng)
         ENG_IDLE: begin
            if (|arb.gnt) begin
               for (int c = NCH - 1; c >= 0; c--) begin
                  if (arb.gnt[c]) begin
                     ci = c[1:0];
                  end
               end
               cc = r.ch[ci];
               maddr = (cc.ctrl[CTL_AM_LO +: 2] == AM_PIND) ? pind_addr_i : cc.cur;
               r_nxt.cur_ch = ci;
               r_nxt.pend[ci] = 1'b0;
               r_nxt.eng = ENG_BUSY;
               r_nxt.xreq = 1'b1;
               // one fixed direction per channel
               r_nxt.xsrc = cc.ctrl[CTL_DIR] ? maddr : cc.pad;
               r_nxt.xdst = cc.ctrl[CTL_DIR] ? cc.pad : maddr;
               r_nxt.xbyte = cc.ctrl[CTL_BYTE];
            end
         end
         ENG_BUSY: begin
            if (xfer_ack_i) begin
               r_nxt.xreq = 1'b0;
               r_nxt.eng = ENG_IDLE;
               dn = r.ch[r.cur_ch].done_n + 14'h0001;
               h15 = {1'b0, cc.cnt} + 15'h0001;
               if (cc.ctrl[CTL_AM_LO +: 2] == AM_INC) begin
                  r_nxt.ch[r.cur_ch].cur = cc.cur + (cc.ctrl[CTL_BYTE] ? STEP_BYTE : STEP_WORD);
               end
               if (cc.ctrl[CTL_HALF] && dn == h15[14:1]) begin
                  r_nxt.stat[{r.cur_ch, 1'b0}] = 1'b1;
               end
               if (cc.done_n == cc.cnt) begin
                  r_nxt.stat[{r.cur_ch, 1'b1}] = 1'b1;
                  r_nxt.ch[r.cur_ch].done_n = '0;
                  if (cc.ctrl[CTL_PP]) begin
                     r_nxt.ch[r.cur_ch].pp = ~cc.pp;
                     r_nxt.ch[r.cur_ch].cur = cc.pp ? cc.sta : cc.stb;
                  end else begin
                     r_nxt.ch[r.cur_ch].cur = cc.sta;
                  end
                  if (cc.ctrl[CTL_ONESHOT]) begin
                     r_nxt.ch[r.cur_ch].ctrl[CTL_EN] = 1'b0;
                  end
               end else begin
                  r_nxt.ch[r.cur_ch].done_n = dn;
               end
            end
         end
      endcase

      // disabled channels drop requests; a new request beats the grant clear
      for (int c = 0; c < NCH; c++) begin
         if (!r_nxt.ch[c].ctrl[CTL_EN]) begin
            r_nxt.pend[c] = 1'b0;
         end else if (ev[c] || force_ev[c]) begin
            r_nxt.pend[c] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r <= '0;
         r.eng <= ENG_IDLE;
      end else begin
         r <= r_nxt;
      end
   end

   assign wb_ack_o = r.ack;
   assign wb_dat_o = r.rdat;
   assign xfer_req_o = r.xreq;
   assign xfer_src_o = r.xsrc;
   assign xfer_dst_o = r.xdst;
   assign xfer_byte_o = r.xbyte;
   assign irq_o = |(r.stat & r.mask);

   // ************************************************
   // checks
   // ************************************************
   sequence s_wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   property p_wb_ack;
      @(posedge clk_i) disable iff (!rstn_i) s_wb_req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack not one cycle after request");

   property p_grant_prio;
      @(posedge clk_i) disable iff (!rstn_i) arb.req[0] |=> (r.cur_ch == 2'd0) && xfer_req_o;
   endproperty
   a_grant_prio: assert property (p_grant_prio) else $error("channel 0 not served first");

   property p_pend_hold;
      @(posedge clk_i) disable iff (!rstn_i)
         (r.pend[3] && r.ch[3].ctrl[CTL_EN] && !arb.gnt[3] && !wr && !(done_ev && done_ch == 2'd3))
         |=> r.pend[3];
   endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("losing request was dropped");

   property p_done_irq;
      @(posedge clk_i) disable iff (!rstn_i) done_ev |=> r.stat[{$past(done_ch), 1'b1}];
   endproperty
   a_done_irq: assert property (p_done_irq) else $error("block done flag not set");

   property p_irq_out;
      @(posedge clk_i) disable iff (!rstn_i) (done_ev && r.mask[{done_ch, 1'b1}] && !wr) |=> irq_o;
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("unmasked done did not raise irq");

   property p_oneshot;
      @(posedge clk_i) disable iff (!rstn_i)
         (done_ev && r.ch[done_ch].ctrl[CTL_ONESHOT]) |=> !r.ch[$past(done_ch)].ctrl[CTL_EN];
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot channel still enabled");

   property p_byte_inc;
      @(posedge clk_i) disable iff (!rstn_i)
         (fin && !done_ev && !wr && r.ch[r.cur_ch].ctrl[CTL_AM_LO +: 2] == AM_INC)
         |=> r.ch[$past(r.cur_ch)].cur == $past(r.ch[r.cur_ch].cur)
             + ($past(r.ch[r.cur_ch].ctrl[CTL_BYTE]) ? STEP_BYTE : STEP_WORD);
   endproperty
   a_byte_inc: assert property (p_byte_inc) else $error("pointer step does not match size");

   property p_fixed;
      @(posedge clk_i) disable iff (!rstn_i)
         (fin && !done_ev && !wr && r.ch[r.cur_ch].ctrl[CTL_AM_LO +: 2] == AM_FIX)
         |=> r.ch[$past(r.cur_ch)].cur == $past(r.ch[r.cur_ch].cur);
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed pointer moved");

   property p_pingpong;
      @(posedge clk_i) disable iff (!rstn_i)
         (done_ev && r.ch[done_ch].ctrl[CTL_PP]) |=> r.ch[$past(done_ch)].pp != $past(r.ch[done_ch].pp);
   endproperty
   a_pingpong: assert property (p_pingpong) else $error("ping-pong buffer not swapped");

   property p_req_hold;
      @(posedge clk_i) disable iff (!rstn_i)
         (xfer_req_o && !xfer_ack_i) |=> xfer_req_o && $stable(xfer_src_o) && $stable(xfer_dst_o);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("transfer request changed before ack");

   // ************************************************
   // move sequencing checks
   // ************************************************
   // half point as 2*moves equal to count or count+1, independent of the engine's own halving
   logic [15:0] move_no;
   logic [15:0] cnt16;
   assign move_no = {2'b00, r.ch[r.cur_ch].done_n} + 16'h0001;
   assign cnt16 = {2'b00, r.ch[r.cur_ch].cnt};

   sequence s_move_ack;
      xfer_req_o && xfer_ack_i;
   endsequence

   sequence s_half_point;
      r.ch[r.cur_ch].ctrl[CTL_HALF]
      && ({move_no[14:0], 1'b0} == cnt16 || {move_no[14:0], 1'b0} == cnt16 + 16'h0001);
   endsequence

   property p_half_flag;
      @(posedge clk_i) disable iff (!rstn_i)
         (s_move_ack ##0 s_half_point) |=> r.stat[{$past(r.cur_ch), 1'b0}];
   endproperty
   a_half_flag: assert property (p_half_flag) else $error("half block flag not set");

   property p_req_drop;
      @(posedge clk_i) disable iff (!rstn_i) s_move_ack |=> !xfer_req_o && (r.eng == ENG_IDLE);
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request not dropped after ack");
endmodule

// ===== verif/xfer_partner.sv
/*
 * Far side of the transfer port: memory and peripheral that finish a move.
 * Assumes clk_i domain; delay_i sets cycles of wait before the ack pulse.
 */
`timescale 1ns/1ps
module xfer_partner (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire logic [3:0] delay_i,
   output logic ack_o
);
   logic [3:0] wait_r;
   // one pulse per request; no second ack while req is still falling
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_o <= 1'b0;
         wait_r <= 4'h0;
      end else begin
         ack_o <= 1'b0;
         if (req_i && !ack_o) begin
            if (wait_r == delay_i) begin
               ack_o <= 1'b1;
               wait_r <= 4'h0;
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule

// ===== verif/testbench.sv
/*
 * Self-checking bench of the transfer controller: Wishbone master tasks,
 * queues of expected moves and reads, a monitor that compares them.
 * Assumes xfer_partner on the transfer port and dma_pkg constants.
 */
`timescale 1ns/1ps
module testbench
   import dma_pkg::*;
;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h00000000;
   logic [31:0] wb_rdat;
   logic wb_ack, xfer_req, xfer_byte, xfer_ack, irq;
   logic [NSRC-1:0] src = '0;
   logic [15:0] pind = 16'h0000;
   logic [15:0] xsrc, xdst;
   logic [3:0] dly = 4'h0;
   logic [15:0] pa[4], sa[4], sb[4];
   logic [32:0] mq[$];
   logic [31:0] rq[$];
   int mismatches = 0;
   int n_checks = 0;
   int cyc_n = 0;

   always #2.5 clk_i = ~clk_i;

   dma_ctrl u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .src_i(src), .pind_addr_i(pind),
      .xfer_req_o(xfer_req), .xfer_src_o(xsrc), .xfer_dst_o(xdst), .xfer_byte_o(xfer_byte),
      .xfer_ack_i(xfer_ack), .irq_o(irq));
   xfer_partner u_far (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(xfer_req), .delay_i(dly),
      .ack_o(xfer_ack));

   // ************************************************
   // checking
   // ************************************************
   task automatic end_of_test();
      if (mq.size() != 0) mismatches++;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // irq is combinational of registers: look at it once settled
   task automatic chk_irq(input logic e);
      @(negedge clk_i);
      chk({32'h0, irq}, {32'h0, e}, "irq");
   endtask

   always @(posedge clk_i) begin
      logic [32:0] e;
      cyc_n++;
      if (cyc_n == 20000) begin
         mismatches++;
         $display("BAD %0t cycle limit reached", $time);
         end_of_test();
      end else begin
         if (xfer_req && xfer_ack) begin
            e = (mq.size() != 0) ? mq.pop_front() : 'x;
            chk({xfer_byte, xsrc, xdst}, e, "move");
         end
         if (wb_ack && !wb_we) chk({1'b0, wb_rdat}, {1'b0, rq.pop_front()}, "read");
      end
   end

   // ************************************************
   // stimulus tasks
   // ************************************************
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= 4'hF;
      if (!w) rq.push_back(e);
      @(posedge clk_i);
      while (wb_ack !== 1'b1) @(posedge clk_i);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask

   task automatic mv(input logic [15:0] s, input logic [15:0] d, input logic b);
      mq.push_back({b, s, d});
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (mq.size() != 0 && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      if (mq.size() != 0) begin
         mismatches++;
         $display("BAD %0t moves still expected after wait", $time);
      end
   endtask

   // setup goes in while the channel is still off
   task automatic setup(input int c, input logic [15:0] ctl, input logic [7:0] sel, input logic [13:0] n);
      logic [7:0] b;
      b = 8'(c * 32);
      wb(b + 8'h08, 1'b1, {16'h0, sa[c]}, 32'h0);
      wb(b + 8'h0C, 1'b1, {16'h0, sb[c]}, 32'h0);
      wb(b + 8'h10, 1'b1, {16'h0, pa[c]}, 32'h0);
      wb(b + 8'h14, 1'b1, {18'h0, n}, 32'h0);
      wb(b + 8'h04, 1'b1, {24'h0, sel}, 32'h0);
      wb(b, 1'b1, {16'h0, ctl}, 32'h0);
   endtask

   task automatic force_req(input int c);
      wb(8'(c * 32) + 8'h04, 1'b1, 32'h000080FF, 32'h0);
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      void'($urandom(32'h9EB9));
      for (int i = 0; i < 4; i++) begin
         pa[i] = 16'($urandom);
         sa[i] = 16'($urandom) & 16'h7FFE;
         sb[i] = 16'($urandom) & 16'h7FFE;
      end
      pind = 16'($urandom);
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      wb(8'h10, 1'b0, 32'h0, 32'h0);
      wb(8'h14, 1'b0, 32'h0, 32'h0);
      wb(8'h14, 1'b1, 32'h0000FFFF, 32'h0);
      wb(8'h14, 1'b0, 32'h0, 32'h00003FFF);
      wb(8'h30, 1'b1, {16'h0, pa[1]}, 32'h0);
      wb(8'h30, 1'b0, 32'h0, {16'h0, pa[1]});
      wb(8'hFC, 1'b1, 32'hFFFFFFFF, 32'h0);
      wb(8'hFC, 1'b0, 32'h0, 32'h0);
      $display("test registers done");
      setup(0, 16'h00A1, 8'hFF, 14'd2);
      // one request moves one unit, so the block needs one force per move
      for (int i = 0; i < 3; i++) begin
         mv(pa[0], sa[0] + 16'(2 * i), 1'b0);
         force_req(0);
         drain();
      end
      wb(8'h00, 1'b0, 32'h0, 32'h000000A0);
      wb(8'h80, 1'b0, 32'h0, 32'h00000003);
      chk_irq(1'b0);
      wb(8'h84, 1'b1, 32'h00000002, 32'h0);
      chk_irq(1'b1);
      force_req(0);
      repeat (10) @(posedge clk_i);
      wb(8'h80, 1'b1, 32'h000000FF, 32'h0);
      chk_irq(1'b0);
      $display("test one-shot done");
      setup(1, 16'h00CF, 8'hFF, 14'd1);
      for (int i = 0; i < 4; i++) begin
         mv(i < 2 ? sa[1] : sb[1], pa[1], 1'b1);
         force_req(1);
         drain();
      end
      wb(8'h80, 1'b0, 32'h0, 32'h0000000C);
      wb(8'h80, 1'b1, 32'h000000FF, 32'h0);
      wb(8'h20, 1'b1, 32'h0, 32'h0);
      $display("test ping-pong done");
      dly <= 4'h6;
      setup(0, 16'h0021, 8'h00, 14'd0);
      setup(2, 16'h0021, 8'h07, 14'd0);
      setup(3, 16'h0021, 8'h0D, 14'd0);
      mv(pa[0], sa[0], 1'b0);
      mv(pa[2], sa[2], 1'b0);
      mv(pa[3], sa[3], 1'b0);
      @(posedge clk_i);
      src[0] <= 1'b1;
      src[7] <= 1'b1;
      src[13] <= 1'b1;
      repeat (4) @(posedge clk_i);
      src <= '0;
      drain();
      wb(8'h80, 1'b0, 32'h0, 32'h000000A2);
      $display("test priority done");
      dly <= 4'h0;
      setup(2, 16'h0031, 8'hFF, 14'd0);
      mv(pa[2], pind, 1'b0);
      force_req(2);
      drain();
      $display("test indirect done");
      end_of_test();
   end
endmodule
